// ==== dv/host_axi_master.sv ====
// Host model that runs AXI4-Lite register cycles towards the guard block.
`timescale 1ns/1ps
module host_axi_master (
  // Clock.
  input wire logic i_clk,
  // Write channels.
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [l1_guard_pkg::ADDR_W-1:0] o_awaddr,
  output logic o_wvalid,
  input wire logic i_wready,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  input wire logic i_bvalid,
  output logic o_bready,
  // Read channels.
  output logic o_arvalid,
  input wire logic i_arready,
  output logic [l1_guard_pkg::ADDR_W-1:0] o_araddr,
  input wire logic i_rvalid,
  output logic o_rready
);
  initial begin
    o_awvalid = 1'b0;
    o_awaddr = '0;
    o_wvalid = 1'b0;
    o_wdata = '0;
    o_wstrb = 4'h0;
    o_bready = 1'b0;
    o_arvalid = 1'b0;
    o_araddr = '0;
    o_rready = 1'b0;
  end

  // Ready levels change only at rising edges, so the level seen at the falling edge
  // is the one sampled at the next rising edge.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic a_now;
    logic w_now;
    logic a_done;
    logic w_done;
    logic b_now;
    a_done = 1'b0;
    w_done = 1'b0;
    @(posedge i_clk);
    o_awvalid <= 1'b1;
    o_awaddr <= a;
    o_wvalid <= 1'b1;
    o_wdata <= d;
    o_wstrb <= 4'hF;
    o_bready <= 1'b1;
    do begin
      @(negedge i_clk);
      a_now = o_awvalid && i_awready;
      w_now = o_wvalid && i_wready;
      @(posedge i_clk);
      if (a_now) o_awvalid <= 1'b0;
      if (w_now) o_wvalid <= 1'b0;
      a_done = a_done || a_now;
      w_done = w_done || w_now;
    end while (!(a_done && w_done));
    do begin
      @(negedge i_clk);
      b_now = i_bvalid;
      @(posedge i_clk);
    end while (!b_now);
    o_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    logic hit;
    @(posedge i_clk);
    o_arvalid <= 1'b1;
    o_araddr <= a;
    o_rready <= 1'b1;
    do begin
      @(negedge i_clk);
      hit = i_arready;
      @(posedge i_clk);
    end while (!hit);
    o_arvalid <= 1'b0;
    do begin
      @(negedge i_clk);
      hit = i_rvalid;
      @(posedge i_clk);
    end while (!hit);
    o_rready <= 1'b0;
  endtask
endmodule

// ==== dv/tb_l1_read_guard.sv ====
// Self-checking bench for the level-one read guard and alarm masks.
`timescale 1ns/1ps
module tb_l1_read_guard;
  import l1_guard_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [9:0] alarms = '0;
  logic irq, chk_valid = 1'b0, chk_write = 1'b0, chk_aux = 1'b0, done, grant;
  logic [7:0] chk_page = '0, chk_addr = '0;
  logic [33:0] exp_rd[$];
  logic exp_chk[$];
  logic [1:0] exp_wr[$];
  int n_errors = 0, checks = 0, cyc = 0;
  localparam logic [31:0] PW = 32'h1234_5678;
  logic [7:0] r_lo[8] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'hF8, 8'h80, 8'hF8, 8'hD0};
  logic [7:0] r_hi[8] = '{8'h7F, 8'hFF, 8'h7A, 8'hF7, 8'hFF, 8'hC7, 8'hFF, 8'hD6};
  logic [7:0] r_out[8] = '{8'h80, 8'h7F, 8'h7B, 8'hF8, 8'hF7, 8'hC8, 8'hF7, 8'hD7};
  logic [7:0] r_pg[8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h04, 8'h05, 8'h05};

  always #25 i_ref_clk = ~i_ref_clk;

  l1_read_guard u_l1_read_guard (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .i_alarm_flags(alarms),
    .o_masked_interrupt_flag(irq), .i_chk_valid(chk_valid), .i_chk_write(chk_write),
    .i_chk_aux(chk_aux), .i_chk_page(chk_page), .i_chk_addr(chk_addr),
    .o_chk_done(done), .o_chk_grant(grant));

  host_axi_master u_host_axi_master (.i_clk(i_ref_clk), .o_awvalid(awvalid),
    .i_awready(awready), .o_awaddr(awaddr), .o_wvalid(wvalid), .i_wready(wready),
    .o_wdata(wdata), .o_wstrb(wstrb), .i_bvalid(bvalid), .o_bready(bready),
    .o_arvalid(arvalid), .i_arready(arready), .o_araddr(araddr), .i_rvalid(rvalid),
    .o_rready(rready));

  function automatic logic [11:0] ba(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic report_and_stop();
    if (exp_rd.size() + exp_chk.size() + exp_wr.size() > 0) begin
      n_errors++;
      $display("BAD pending_results exp %0d seen %0d", 0,
               exp_rd.size() + exp_chk.size() + exp_wr.size());
    end
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    exp_wr.push_back(r);
    u_host_axi_master.wr(ba(idx), d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [1:0] r, input logic [31:0] d);
    exp_rd.push_back({r, d});
    u_host_axi_master.rd(a);
  endtask

  task automatic chk(input logic w, x, input logic [7:0] p, a, input logic g);
    exp_chk.push_back(g);
    @(posedge i_ref_clk);
    chk_valid <= 1'b1;
    chk_write <= w;
    chk_aux <= x;
    chk_page <= p;
    chk_addr <= a;
    @(posedge i_ref_clk);
    chk_valid <= 1'b0;
  endtask

  // Results are compared here as they appear at the outputs.
  always @(negedge i_ref_clk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && exp_rd.size() > 0) begin
      checks++;
      if ({rresp, rdata} !== exp_rd[0]) begin
        n_errors++;
        $display("BAD read_resp_data exp %h seen %h", exp_rd[0], {rresp, rdata});
      end
      if (araddr == ba(IDX_STATUS)) begin
        checks++;
        if (irq !== exp_rd[0][0]) begin
          n_errors++;
          $display("BAD masked_interrupt_flag exp %b seen %b", exp_rd[0][0], irq);
        end
      end
      void'(exp_rd.pop_front());
    end
    if (bvalid === 1'b1 && bready === 1'b1 && exp_wr.size() > 0) begin
      checks++;
      if (bresp !== exp_wr[0]) begin
        n_errors++;
        $display("BAD write_resp exp %h seen %h", exp_wr[0], bresp);
      end
      void'(exp_wr.pop_front());
    end
    if (done === 1'b1 && exp_chk.size() > 0) begin
      checks++;
      if (grant !== exp_chk[0]) begin
        n_errors++;
        $display("BAD chk_grant exp %b seen %b", exp_chk[0], grant);
      end
      void'(exp_chk.pop_front());
    end
  end

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    logic [7:0] a, m, m3;
    logic [9:0] f;
    logic q;
    a = 8'($urandom(98));
    repeat (8) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    rd_chk(ba(IDX_READ_ENABLE), RESP_OKAY, 32'h0000_0000);
    rd_chk(ba(IDX_PASSWORD), RESP_OKAY, 32'h0000_0000);
    rd_chk(ba(IDX_MASK_LOW), RESP_OKAY, 32'h0000_0000);
    rd_chk(ba(IDX_MASK_EXT_MONITOR_INPUT_C), RESP_OKAY, 32'h0000_0000);
    rd_chk(12'h000, RESP_DECERR, 32'h0000_0000);
    wr(10'h000, 32'hFFFF_FFFF, RESP_DECERR);
    chk(1'b0, 1'b0, PAGE_05, A_PW_LO, 1'b1);
    wr(IDX_PASSWORD, PW);
    rd_chk(ba(IDX_PASSWORD), RESP_OKAY, PW);
    rd_chk(ba(IDX_STATUS), RESP_OKAY, 32'h0000_0000);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) begin
      wr(IDX_READ_ENABLE, 32'h1 << i);
      wr(IDX_WRITE_ENABLE, 32'h1 << i);
      a = r_lo[i] + 8'($urandom % (r_hi[i] - r_lo[i] + 1));
      chk(1'b0, i < 2, r_pg[i], a, 1'b0);
      chk(1'b0, i < 2, r_pg[i], r_out[i], 1'b1);
      chk(1'b1, i < 2, r_pg[i], a, 1'b0);
      rd_chk(ba(IDX_READ_ENABLE), RESP_OKAY, (i == 7) ? 32'h0 : 32'h1 << i);
    end
    chk(1'b0, 1'b0, PAGE_02, 8'h80, 1'b1);
    $display("test regions done");
    wr(IDX_PW_ENTRY, PW ^ 32'h0000_0001);
    chk(1'b0, 1'b0, PAGE_05, A_PW_HI, 1'b0);
    wr(IDX_PW_ENTRY, PW);
    chk(1'b0, 1'b0, PAGE_05, A_PW_HI, 1'b1);
    chk(1'b1, 1'b0, PAGE_05, A_PW_LO, 1'b1);
    rd_chk(ba(IDX_READ_ENABLE), RESP_OKAY, 32'h0000_0080);
    rd_chk(ba(IDX_PW_ENTRY), RESP_OKAY, 32'h0000_0000);
    rd_chk(ba(IDX_STATUS), RESP_OKAY, 32'h0000_0002);
    wr(IDX_PW_ENTRY, 32'h0000_0000);
    wr(IDX_PASSWORD, 32'h0000_0000);
    rd_chk(ba(IDX_PASSWORD), RESP_OKAY, 32'h0000_0000);
    wr(IDX_PW_ENTRY, PW);
    rd_chk(ba(IDX_PASSWORD), RESP_OKAY, PW);
    $display("test unlock done");
    wr(IDX_WRITE_ENABLE, 32'h0);
    for (int k = 0; k < 6; k++) begin
      m = (k == 0) ? 8'h00 : 8'($urandom);
      m3 = (k == 0) ? 8'h00 : 8'($urandom);
      f = (k == 0) ? 10'h3FF : 10'($urandom);
      wr(IDX_MASK_LOW, {24'h0, m});
      wr(IDX_MASK_EXT_MONITOR_INPUT_C, {24'h0, m3});
      rd_chk(ba(IDX_MASK_EXT_MONITOR_INPUT_C), RESP_OKAY, {24'h0, m3 & EXT_MONITOR_INPUT_C_USED_BITS});
      @(posedge i_ref_clk);
      alarms <= f;
      q = |(f & {m, m3[7:6]});
      rd_chk(ba(IDX_STATUS), RESP_OKAY, {30'h0, 1'b1, q});
    end
    $display("test alarm_masks done");
    wr(IDX_MASK_LOW, 32'h0000_00FF);
    wr(IDX_MASK_CFG, 32'h0000_0001);
    @(posedge i_ref_clk);
    alarms <= 10'h3FF;
    rd_chk(ba(IDX_STATUS), RESP_OKAY, 32'h0000_0002);
    wr(IDX_ALT_MASK_LOW, 32'h0000_0001);
    @(posedge i_ref_clk);
    alarms <= 10'h004;
    rd_chk(ba(IDX_STATUS), RESP_OKAY, 32'h0000_0003);
    wr(IDX_MASK_CFG, 32'h0000_0000);
    wr(IDX_MASK_LOW, 32'h0000_00FE);
    rd_chk(ba(IDX_STATUS), RESP_OKAY, 32'h0000_0002);
    $display("test mask_location done");
    wr(IDX_READ_ENABLE, 32'h0000_0028);
    wr(IDX_MASK_CFG, 32'h0000_0002);
    wr(IDX_PW_ENTRY, 32'h0000_0000);
    chk(1'b0, 1'b0, PAGE_00, 8'h80, 1'b0);
    chk(1'b0, 1'b0, PAGE_01, 8'h80, 1'b0);
    chk(1'b0, 1'b0, PAGE_04, 8'h80, 1'b1);
    $display("test legacy_map done");
    repeat (4) @(posedge i_ref_clk);
    report_and_stop();
  end
endmodule

// ==== rtl/l1_guard_pkg.sv ====
// Package with register map, field positions and reset values of the read guard block.
package l1_guard_pkg;

  // ****************************************
  // Bus and register indices
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_WRITE_ENABLE = 10'h0D1;
  localparam logic [IDX_W-1:0] IDX_READ_ENABLE = 10'h0D2;
  localparam logic [IDX_W-1:0] IDX_PASSWORD = 10'h0D3;
  localparam logic [IDX_W-1:0] IDX_MASK_CFG = 10'h0DA;
  localparam logic [IDX_W-1:0] IDX_MASK_LOW = 10'h0F8;
  localparam logic [IDX_W-1:0] IDX_MASK_EXT_MONITOR_INPUT_C = 10'h0F9;
  localparam logic [IDX_W-1:0] IDX_ALT_MASK_LOW = 10'h1F8;
  localparam logic [IDX_W-1:0] IDX_ALT_MASK_EXT_MONITOR_INPUT_C = 10'h1F9;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h071;
  localparam logic [IDX_W-1:0] IDX_PW_ENTRY = 10'h07B;

  // ****************************************
  // Reset values and field layout
  // ****************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_PASSWORD = 32'h0000_0000;
  localparam logic [7:0] EXT_MONITOR_INPUT_C_USED_BITS = 8'hC0;
  localparam int CFG_MASK_LOC_BIT = 0;
  localparam int CFG_LEGACY_BIT = 1;
  localparam int ST_MASKED_INTERRUPT_FLAG_BIT = 0;
  localparam int ST_UNLOCK_BIT = 1;
  localparam int NUM_ALARMS = 10;
  localparam int NUM_REGIONS = 8;

  // Region numbers equal the bit positions of the enable bytes.
  localparam int RGN_PW_BLOCK = 7;
  localparam int RGN_MASK_P05 = 6;
  localparam int RGN_THRESH = 5;
  localparam int RGN_P01_HI = 4;
  localparam int RGN_P01_LO = 3;
  localparam int RGN_LOWER = 2;
  localparam int RGN_AUX_HI = 1;
  localparam int RGN_AUX_LO = 0;

  // ****************************************
  // Pages and byte bounds
  // ****************************************
  localparam logic [7:0] PAGE_00 = 8'h00;
  localparam logic [7:0] PAGE_01 = 8'h01;
  localparam logic [7:0] PAGE_02 = 8'h02;
  localparam logic [7:0] PAGE_03 = 8'h03;
  localparam logic [7:0] PAGE_04 = 8'h04;
  localparam logic [7:0] PAGE_05 = 8'h05;
  localparam logic [7:0] A_PW_LO = 8'hD0;
  localparam logic [7:0] A_PW_HI = 8'hD6;
  localparam logic [7:0] A_MASK_LO = 8'hF8;
  localparam logic [7:0] A_UPPER_LO = 8'h80;
  localparam logic [7:0] A_THRESH_HI = 8'hC7;
  localparam logic [7:0] A_P01_LO_HI = 8'hF7;
  localparam logic [7:0] A_LOWER_HI = 8'h7A;
  localparam logic [7:0] A_AUX_LO_HI = 8'h7F;

  // ****************************************
  // Bus responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

endpackage

// ==== rtl/l1_read_guard.sv ====
// Level-one password guard with alarm interrupt masks behind an AXI4-Lite slave.
`timescale 1ns/1ps
// Behaviour
// - Read-enable bit 7 guards page 05h bytes D0h to D6h.
// - Read-enable bit 6 guards page 05h bytes F8h to FFh.
// - Read-enable bit 5 guards 80h to C7h of threshold page, pages 02h, 03h.
// - Read-enable bit 4 guards F8h to FFh of page 01h, legacy 00h.
// - Read-enable bit 3 guards 80h to F7h of page 01h, legacy 00h.
// - Read-enable bit 2 guards lower memory bytes 00h to 7Ah.
// - Read-enable bit 1 guards auxiliary memory bytes 80h to FFh.
// - Read-enable bit 0 guards auxiliary memory bytes 00h to 7Fh.
// - Read-enable byte resets to 00h, nothing guarded.
// - Password is 32 bits, first byte most significant, reset zero.
// - Stored password unlocks regions of write-enable and read-enable bytes.
// - Alarm mask bits 7..0 enable temperature, supply, input a, b alarms.
// - Second mask byte bit 7, 6 enable input c alarms; rest reserved.
// - Active alarm with mask bit set raises the masked interrupt flag.
// - Mask location bit selects which mask copy gates the flag.
// - Both alarm mask bytes reset to 00h.
// - Location 0 uses page 05h masks, 1 uses page 01h masks.
// - Write-enable byte guards the same eight regions against writes.
module l1_read_guard (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // AXI4-Lite write channels.
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [l1_guard_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // AXI4-Lite read channels.
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [l1_guard_pkg::ADDR_W-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // Alarm flags from the flag logic on this clock.
  input wire logic [l1_guard_pkg::NUM_ALARMS-1:0] i_alarm_flags,
  output logic o_masked_interrupt_flag,
  // Access check from the serial memory front end.
  input wire logic i_chk_valid,
  input wire logic i_chk_write,
  input wire logic i_chk_aux,
  input wire logic [7:0] i_chk_page,
  input wire logic [7:0] i_chk_addr,
  output logic o_chk_done,
  output logic o_chk_grant
);
  import l1_guard_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] write_enable;
  logic [7:0] read_enable;
  logic [31:0] level1_password;
  logic [31:0] pw_entry;
  logic [7:0] mask_cfg;
  logic [7:0] mask_low;
  logic [7:0] mask_ext_monitor_input_c;
  logic [7:0] alt_mask_low;
  logic [7:0] alt_mask_ext_monitor_input_c;
  logic unlocked;

  logic aw_full;
  logic w_full;
  logic [IDX_W-1:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;
  logic [IDX_W-1:0] rd_idx;

  logic [NUM_REGIONS-1:0] wr_rgn;
  logic [NUM_REGIONS-1:0] rd_rgn;
  logic wr_blocked;
  logic rd_hidden;
  logic wr_mapped;
  logic rd_mapped;
  logic [31:0] next_rdata;

  logic [NUM_ALARMS-1:0] main_vec;
  logic [NUM_ALARMS-1:0] alt_vec;
  logic [NUM_ALARMS-1:0] sel_mask;
  logic [NUM_ALARMS-1:0] gated;
  logic [NUM_REGIONS-1:0] chk_hit;
  logic [7:0] chk_enable;

  // Password match opens every guarded region at once.
  assign unlocked = (pw_entry == level1_password);

  // Regions that hold the bus-visible registers themselves.
  function automatic logic [NUM_REGIONS-1:0] reg_region(input logic [IDX_W-1:0] idx);
    logic [NUM_REGIONS-1:0] r;
    r = '0;
    case (idx)
      IDX_WRITE_ENABLE, IDX_READ_ENABLE, IDX_PASSWORD: r[RGN_PW_BLOCK] = 1'b1;
      IDX_MASK_LOW, IDX_MASK_EXT_MONITOR_INPUT_C: r[RGN_MASK_P05] = 1'b1;
      IDX_ALT_MASK_LOW, IDX_ALT_MASK_EXT_MONITOR_INPUT_C: r[RGN_P01_HI] = 1'b1;
      IDX_STATUS: r[RGN_LOWER] = 1'b1;
      default: r = '0;
    endcase
    return r;
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_WRITE_ENABLE, IDX_READ_ENABLE, IDX_PASSWORD, IDX_MASK_CFG, IDX_MASK_LOW,
      IDX_MASK_EXT_MONITOR_INPUT_C, IDX_ALT_MASK_LOW, IDX_ALT_MASK_EXT_MONITOR_INPUT_C, IDX_STATUS,
      IDX_PW_ENTRY: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign wr_fire = aw_full && w_full && !o_s_axi_bvalid;
  assign wr_rgn = reg_region(aw_idx);
  assign wr_mapped = is_mapped(aw_idx);
  assign wr_blocked = (|(wr_rgn & write_enable)) && !unlocked;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_full <= 1'b0;
      aw_idx <= '0;
      o_s_axi_awready <= 1'b1;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_full <= 1'b1;
      aw_idx <= i_s_axi_awaddr[ADDR_W-1:2];
      o_s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_full <= 1'b0;
      o_s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      o_s_axi_wready <= 1'b1;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= i_s_axi_wdata;
      w_strb <= i_s_axi_wstrb;
      o_s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_full <= 1'b0;
      o_s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // Byte registers take lane 0; blocked writes are dropped with an OKAY answer.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      write_enable <= RST_BYTE;
      read_enable <= RST_BYTE;
      mask_cfg <= RST_BYTE;
      mask_low <= RST_BYTE;
      mask_ext_monitor_input_c <= RST_BYTE;
      alt_mask_low <= RST_BYTE;
      alt_mask_ext_monitor_input_c <= RST_BYTE;
    end else if (wr_fire && !wr_blocked && w_strb[0]) begin
      case (aw_idx)
        IDX_WRITE_ENABLE: write_enable <= w_data[7:0];
        IDX_READ_ENABLE: read_enable <= w_data[7:0];
        IDX_MASK_CFG: mask_cfg <= w_data[7:0];
        IDX_MASK_LOW: mask_low <= w_data[7:0];
        IDX_MASK_EXT_MONITOR_INPUT_C: mask_ext_monitor_input_c <= w_data[7:0] & EXT_MONITOR_INPUT_C_USED_BITS;
        IDX_ALT_MASK_LOW: alt_mask_low <= w_data[7:0];
        IDX_ALT_MASK_EXT_MONITOR_INPUT_C: alt_mask_ext_monitor_input_c <= w_data[7:0] & EXT_MONITOR_INPUT_C_USED_BITS;
        default: ;
      endcase
    end
  end

  // Word registers honour every byte lane; lane 3 holds the most significant byte.
  generate
    for (genvar b = 0; b < 4; b++) begin : g_pw_lane
      always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          level1_password[8*b +: 8] <= RST_PASSWORD[8*b +: 8];
          pw_entry[8*b +: 8] <= RST_PASSWORD[8*b +: 8];
        end else if (wr_fire && w_strb[b]) begin
          if (aw_idx == IDX_PASSWORD && !wr_blocked) begin
            level1_password[8*b +: 8] <= w_data[8*b +: 8];
          end
          if (aw_idx == IDX_PW_ENTRY) begin
            pw_entry[8*b +: 8] <= w_data[8*b +: 8];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  assign rd_fire = i_s_axi_arvalid && o_s_axi_arready;
  assign rd_idx = i_s_axi_araddr[ADDR_W-1:2];
  assign rd_rgn = reg_region(rd_idx);
  assign rd_mapped = is_mapped(rd_idx);
  assign rd_hidden = (|(rd_rgn & read_enable)) && !unlocked;

  always_comb begin
    next_rdata = '0;
    case (rd_idx)
      IDX_WRITE_ENABLE: next_rdata[7:0] = write_enable;
      IDX_READ_ENABLE: next_rdata[7:0] = read_enable;
      IDX_PASSWORD: next_rdata = level1_password;
      IDX_MASK_CFG: next_rdata[7:0] = mask_cfg;
      IDX_MASK_LOW: next_rdata[7:0] = mask_low;
      IDX_MASK_EXT_MONITOR_INPUT_C: next_rdata[7:0] = mask_ext_monitor_input_c;
      IDX_ALT_MASK_LOW: next_rdata[7:0] = alt_mask_low;
      IDX_ALT_MASK_EXT_MONITOR_INPUT_C: next_rdata[7:0] = alt_mask_ext_monitor_input_c;
      IDX_STATUS: begin
        next_rdata[ST_MASKED_INTERRUPT_FLAG_BIT] = o_masked_interrupt_flag;
        next_rdata[ST_UNLOCK_BIT] = unlocked;
      end
      default: next_rdata = '0;
    endcase
    if (rd_hidden) begin
      next_rdata = '0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= '0;
      o_s_axi_rresp <= RESP_OKAY;
      o_s_axi_arready <= 1'b1;
    end else if (rd_fire) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= next_rdata;
      o_s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_DECERR;
      o_s_axi_arready <= 1'b0;
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Masked interrupt
  // ****************************************
  assign main_vec = {mask_low, mask_ext_monitor_input_c[7:6]};
  assign alt_vec = {alt_mask_low, alt_mask_ext_monitor_input_c[7:6]};
  assign sel_mask = mask_cfg[CFG_MASK_LOC_BIT] ? alt_vec : main_vec;

  generate
    for (genvar a = 0; a < NUM_ALARMS; a++) begin : g_alarm
      assign gated[a] = i_alarm_flags[a] & sel_mask[a];
    end
  endgenerate

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_masked_interrupt_flag <= 1'b0;
    end else begin
      o_masked_interrupt_flag <= |gated;
    end
  end

  // ****************************************
  // Memory access check
  // ****************************************
  l1_region_decode u_region (
    .i_aux(i_chk_aux),
    .i_legacy(mask_cfg[CFG_LEGACY_BIT]),
    .i_page(i_chk_page),
    .i_addr(i_chk_addr),
    .o_hit(chk_hit)
  );

  assign chk_enable = i_chk_write ? write_enable : read_enable;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_chk_done <= 1'b0;
      o_chk_grant <= 1'b0;
    end else begin
      o_chk_done <= i_chk_valid;
      o_chk_grant <= i_chk_valid && (unlocked || !(|(chk_hit & chk_enable)));
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_MASKED_INTERRUPT_FLAG_SET: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (|(i_alarm_flags & sel_mask)) |=> o_masked_interrupt_flag)
    else $error("Masked alarm did not raise interrupt flag");

  AST_MASKED_INTERRUPT_FLAG_MASKED: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (!(|(i_alarm_flags & sel_mask))) |=> !o_masked_interrupt_flag)
    else $error("Interrupt flag raised with no enabled alarm");

  AST_MASK_LOC: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (mask_cfg[CFG_MASK_LOC_BIT] && !(|(i_alarm_flags & alt_vec))) |=> !o_masked_interrupt_flag)
    else $error("Page 05h masks used while alternate location selected");

  AST_EXT_MONITOR_INPUT_C_RSVD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    $rose(wr_fire) && aw_idx == IDX_MASK_EXT_MONITOR_INPUT_C |=> mask_ext_monitor_input_c[5:0] == '0)
    else $error("Reserved mask bits stored");

  AST_CHK_DENY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_chk_valid && !i_chk_write && !unlocked && |(chk_hit & read_enable))
    |=> o_chk_done && !o_chk_grant)
    else $error("Guarded read granted while locked");

  AST_CHK_OPEN: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_chk_valid && unlocked) |=> o_chk_done && o_chk_grant)
    else $error("Read refused while password matches");

  AST_PW_KEEP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (wr_fire && aw_idx == IDX_PASSWORD && write_enable[RGN_PW_BLOCK] && !unlocked)
    |=> $stable(level1_password))
    else $error("Guarded password overwritten while locked");

  AST_PW_HIDE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (rd_fire && rd_idx == IDX_PASSWORD && read_enable[RGN_PW_BLOCK] && !unlocked)
    |=> o_s_axi_rvalid && o_s_axi_rdata == '0)
    else $error("Guarded password exposed while locked");

  AST_BRESP_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (o_s_axi_bvalid && !i_s_axi_bready) |=> o_s_axi_bvalid)
    else $error("Write response dropped before bready");

endmodule

// ==== rtl/l1_region_decode.sv ====
// Decoder that maps a memory access to the protection regions it falls in.
`timescale 1ns/1ps
module l1_region_decode (
  // Access being classified.
  input wire logic i_aux,
  input wire logic i_legacy,
  input wire logic [7:0] i_page,
  input wire logic [7:0] i_addr,
  // One bit per region.
  output logic [l1_guard_pkg::NUM_REGIONS-1:0] o_hit
);
  import l1_guard_pkg::*;

  logic [7:0] thresh_page;
  logic [7:0] cfg_page;
  logic upper;

  always_comb begin
    thresh_page = i_legacy ? PAGE_01 : PAGE_04;
    cfg_page = i_legacy ? PAGE_00 : PAGE_01;
    upper = (i_addr >= A_UPPER_LO);
    o_hit = '0;
    if (i_aux) begin
      o_hit[RGN_AUX_HI] = upper;
      o_hit[RGN_AUX_LO] = (i_addr <= A_AUX_LO_HI);
    end else begin
      o_hit[RGN_LOWER] = (i_addr <= A_LOWER_HI);
      o_hit[RGN_PW_BLOCK] = upper && (i_page == PAGE_05) && (i_addr >= A_PW_LO)
                            && (i_addr <= A_PW_HI);
      o_hit[RGN_MASK_P05] = upper && (i_page == PAGE_05) && (i_addr >= A_MASK_LO);
      o_hit[RGN_THRESH] = upper && (i_addr <= A_THRESH_HI) && ((i_page == thresh_page)
                          || (i_page == PAGE_02) || (i_page == PAGE_03));
      o_hit[RGN_P01_HI] = upper && (i_page == cfg_page) && (i_addr >= A_MASK_LO);
      o_hit[RGN_P01_LO] = upper && (i_page == cfg_page) && (i_addr <= A_P01_LO_HI);
    end
  end

endmodule
